// [pkg/tcsr_pkg.sv]
package tcsr_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register numbers
    localparam logic [7:0] TCSR_TILE_CONTROL = 8'h02;
    localparam logic [7:0] TCSR_BOOT_STATUS  = 8'h03;
    localparam logic [7:0] TCSR_PROTECTION   = 8'h05;
    localparam logic [7:0] TCSR_OSC_CONTROL  = 8'h06;
    localparam logic [7:0] TCSR_OSC_COUNT0   = 8'h07;
    localparam int         TCSR_NUM_OSC      = 4;

    ////////////////////////////////////////////////////////////////////
    // Tile control fields
    localparam int TCSR_TXDLY_LSB = 18;
    localparam int TCSR_TXDLY_W   = 8;
    localparam int TCSR_TXDIV_LSB = 9;
    localparam int TCSR_TXDIV_W   = 9;
    localparam int TCSR_PORT_EN   = 8;
    localparam int TCSR_DIV_DYN   = 5;
    localparam int TCSR_DIV_EN    = 4;
    localparam logic [31:0] TCSR_CTRL_MASK  = 32'h03FF_FF30;
    localparam logic [31:0] TCSR_CTRL_RESET = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // Boot status fields
    localparam int TCSR_BS_PROC_LSB = 16;
    localparam int TCSR_BS_OVERRIDE = 8;
    localparam int TCSR_BS_CORE1    = 5;
    localparam int TCSR_BS_NO_POLL  = 4;
    localparam int TCSR_BS_RAM      = 3;
    localparam int TCSR_BS_JTAG     = 2;
    localparam int TCSR_BS_PLL_LSB  = 0;

    ////////////////////////////////////////////////////////////////////
    // Protection settings fields
    localparam int TCSR_PR_WLOCK    = 31;
    localparam int TCSR_PR_GDEBUG   = 14;
    localparam int TCSR_PR_MLOCK    = 12;
    localparam int TCSR_PR_SLOCK    = 8;
    localparam int TCSR_PR_REDUND   = 7;
    localparam int TCSR_PR_PBOOT    = 5;
    localparam int TCSR_PR_PLLJTAG  = 4;
    localparam int TCSR_PR_TAPJTAG  = 0;
    localparam logic [31:0] TCSR_PROT_MASK = 32'h8000_5FB1;

    ////////////////////////////////////////////////////////////////////
    // Oscillator control fields
    localparam int TCSR_OSC_CORE = 1;
    localparam int TCSR_OSC_PERI = 0;
    localparam logic [1:0] TCSR_OSC_RESET = 2'h0;
    localparam int TCSR_CNT_W = 16;

endpackage

// [src/tcsr_regs.sv]
module tcsr_regs
    import tcsr_pkg::*;
(
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    // Status access port
    input  wire logic                   ps_wr,
    input  wire logic                   ps_rd,
    input  wire logic [7:0]             ps_num,
    input  wire logic [31:0]            ps_wdata,
    output logic      [31:0]            ps_rdata,
    output logic                        ps_rvalid,
    // Boot straps and status
    input  wire logic [7:0]             proc_number,
    input  wire logic                   core1_powered,
    input  wire logic                   boot_from_ram,
    input  wire logic                   boot_from_jtag,
    input  wire logic                   skip_otp_poll,
    input  wire logic [1:0]             boot_pll_mode,
    input  wire logic [31:0]            otp_security_word,
    // Thread activity
    input  wire logic                   threads_all_paused,
    // Oscillator edges, one pulse per oscillator edge
    input  wire logic [TCSR_NUM_OSC-1:0] osc_tick,
    // Transmit port timing
    output logic                        rgmii_port_en,
    output logic                        rgmii_tx_clk,
    output logic                        rgmii_tx_data_strobe,
    // Low-power clock divider
    output logic                        core_clk_divide,
    // Protection outputs
    output logic                        global_debug_block,
    output logic                        otp_master_lock,
    output logic [3:0]                  otp_sector_lock,
    output logic                        otp_redundancy_en,
    output logic                        protected_boot_select,
    output logic                        pll_jtag_block,
    output logic                        tap_jtag_block,
    // Oscillator run state
    output logic                        core_oscillator_run,
    output logic                        peripheral_oscillator_run
);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0]              ctrl_q;
    logic [31:0]              prot_q;
    logic [1:0]               osc_ctrl_q;
    logic [31:0]              boot_q;
    logic [TCSR_TXDIV_W-1:0]  div_cnt_q;
    logic                     tx_clk_q;
    logic [TCSR_TXDLY_W-1:0]  dly_cnt_q;
    logic                     dly_busy_q;
    logic                     strobe_q;
    logic                     cdiv_q;
    logic [31:0]              rdata_q;
    logic                     rvalid_q;
    // Oscillator counts start at zero at power-up only; reset leaves them alone
    logic [TCSR_CNT_W-1:0]    osc_cnt_q [TCSR_NUM_OSC] = '{default: '0};

    wire                      wr_ctrl;
    wire                      wr_prot;
    wire                      wr_osc;
    wire [TCSR_TXDIV_W-1:0]   div_val;
    wire [TCSR_TXDIV_W-1:0]   div_half;
    wire [TCSR_TXDLY_W-1:0]   dly_val;
    wire                      div_wrap;
    wire                      tx_rise;
    wire                      tx_fall;
    wire                      cdiv_d;
    wire [31:0]               boot_d;
    wire [31:0]               osc_word;
    wire                      osc_sel;
    wire [1:0]                osc_idx;
    wire [31:0]               rd_mux;
    wire [TCSR_NUM_OSC-1:0]   osc_run;

    ////////////////////////////////////////////////////////////////////
    // Write decode
    // Locked protection writes are dropped without any answer to the writer
    // Boot status and oscillator counts have no write path at all
    assign wr_ctrl = ps_wr && (ps_num == TCSR_TILE_CONTROL);
    assign wr_prot = ps_wr && (ps_num == TCSR_PROTECTION)
                     && !prot_q[TCSR_PR_WLOCK];
    assign wr_osc  = ps_wr && (ps_num == TCSR_OSC_CONTROL);

    // Tile control register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_q <= TCSR_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= ps_wdata & TCSR_CTRL_MASK;
        end
    end

    // Protection settings, loaded from OTP during reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prot_q <= otp_security_word & TCSR_PROT_MASK;
        end else if (wr_prot) begin
            prot_q <= ps_wdata & TCSR_PROT_MASK;
        end
    end

    // Oscillator control
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            osc_ctrl_q <= TCSR_OSC_RESET;
        end else if (wr_osc) begin
            osc_ctrl_q <= ps_wdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control field taps
    // Divider field holds the ratio minus one, exactly as software loads it
    assign dly_val  = ctrl_q[TCSR_TXDLY_LSB +: TCSR_TXDLY_W];
    assign div_val  = ctrl_q[TCSR_TXDIV_LSB +: TCSR_TXDIV_W];
    assign div_half = div_val >> 1;
    assign rgmii_port_en = ctrl_q[TCSR_PORT_EN];

    // Transmit clock counter events
    assign div_wrap = (div_cnt_q >= div_val);
    assign tx_rise  = rgmii_port_en && (div_cnt_q == div_val);
    assign tx_fall  = rgmii_port_en && (div_cnt_q == div_half);

    // Transmit clock divider counter
    // Restarts at zero after each match, so one period is divider plus one
    // A smaller divider written mid-count wraps at once rather than running on
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !rgmii_port_en) begin
            div_cnt_q <= '0;
        end else if (div_wrap) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= div_cnt_q + 1'b1;
        end
    end

    // Transmit clock level; rise wins when both match
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !rgmii_port_en) begin
            tx_clk_q <= 1'b0;
        end else if (tx_rise) begin
            tx_clk_q <= 1'b1;
        end else if (tx_fall) begin
            tx_clk_q <= 1'b0;
        end
    end

    // Transmit data delay after each clock rise
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !rgmii_port_en) begin
            dly_cnt_q  <= '0;
            dly_busy_q <= 1'b0;
        end else if (tx_rise) begin
            dly_cnt_q  <= dly_val;
            dly_busy_q <= (dly_val != '0);
        end else if (dly_busy_q) begin
            dly_cnt_q  <= dly_cnt_q - 1'b1;
            dly_busy_q <= (dly_cnt_q != 8'h01);
        end
    end

    // Data strobe issued once the delay has run out
    // A delay that outlasts the period is restarted by the next rise
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !rgmii_port_en) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= (tx_rise && (dly_val == '0))
                        || (dly_busy_q && (dly_cnt_q == 8'h01));
        end
    end

    assign rgmii_tx_clk         = tx_clk_q;
    assign rgmii_tx_data_strobe = strobe_q;

    ////////////////////////////////////////////////////////////////////
    // Low-power divider engage, static or dynamic
    // Dynamic mode follows the pause flag one cycle late
    assign cdiv_d = ctrl_q[TCSR_DIV_EN]
                    && (!ctrl_q[TCSR_DIV_DYN] || threads_all_paused);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cdiv_q <= 1'b0;
        end else begin
            cdiv_q <= cdiv_d;
        end
    end

    assign core_clk_divide = cdiv_q;

    ////////////////////////////////////////////////////////////////////
    // Protection outputs
    // Master lock folds into every sector lock so each sector sees one bit
    assign global_debug_block    = prot_q[TCSR_PR_GDEBUG];
    assign otp_master_lock       = prot_q[TCSR_PR_MLOCK];
    assign otp_sector_lock       = prot_q[TCSR_PR_SLOCK +: 4]
                                   | {4{prot_q[TCSR_PR_MLOCK]}};
    assign otp_redundancy_en     = prot_q[TCSR_PR_REDUND];
    assign protected_boot_select = prot_q[TCSR_PR_PBOOT];
    assign pll_jtag_block        = prot_q[TCSR_PR_PLLJTAG];
    assign tap_jtag_block        = prot_q[TCSR_PR_TAPJTAG];

    ////////////////////////////////////////////////////////////////////
    // Boot status word, sampled every cycle
    // Bit 8 mirrors the protected boot select, the only override here
    assign boot_d = {8'h00,
                     proc_number,
                     7'h00,
                     prot_q[TCSR_PR_PBOOT],
                     2'h0,
                     core1_powered,
                     skip_otp_poll,
                     boot_from_ram,
                     boot_from_jtag,
                     boot_pll_mode};

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            boot_q <= '0;
        end else begin
            boot_q <= boot_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Oscillator counters, never reset
    // Core pair follows control bit 1, peripheral pair bit 0
    assign core_oscillator_run       = osc_ctrl_q[TCSR_OSC_CORE];
    assign peripheral_oscillator_run = osc_ctrl_q[TCSR_OSC_PERI];
    assign osc_run = {peripheral_oscillator_run, peripheral_oscillator_run,
                      core_oscillator_run, core_oscillator_run};

    for (genvar g = 0; g < TCSR_NUM_OSC; g++) begin : g_osc
        // Counts oscillator edges while running; ticks arrive already synchronous
        // No reset term, so a system reset keeps the count
        always_ff @(posedge ref_clk) begin
            if (osc_run[g] && osc_tick[g]) begin
                osc_cnt_q[g] <= osc_cnt_q[g] + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read selection
    // The gap at 0x04 and every unmapped number read as zero
    assign osc_sel  = (ps_num >= TCSR_OSC_COUNT0)
                      && (ps_num < TCSR_OSC_COUNT0 + 8'(TCSR_NUM_OSC));
    assign osc_idx  = 2'(ps_num - TCSR_OSC_COUNT0);
    assign osc_word = {16'h0000, osc_cnt_q[osc_idx]};

    assign rd_mux = (ps_num == TCSR_TILE_CONTROL) ? ctrl_q :
                    (ps_num == TCSR_BOOT_STATUS)  ? boot_q :
                    (ps_num == TCSR_PROTECTION)   ? prot_q :
                    (ps_num == TCSR_OSC_CONTROL)  ? {30'h0, osc_ctrl_q} :
                    osc_sel                       ? osc_word :
                    32'h0000_0000;

    // Read data register, one cycle after the request
    // Data holds until the next read, so software may take it late
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= ps_rd ? rd_mux : rdata_q;
            rvalid_q <= ps_rd;
        end
    end

    assign ps_rdata  = rdata_q;
    assign ps_rvalid = rvalid_q;

endmodule // tcsr_regs

// [tb/tcsr_regs_props.sv]
module tcsr_regs_checker
    import tcsr_pkg::*;
(
    // Clock, reset and access port
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        ps_wr,
    input wire logic        ps_rd,
    input wire logic [7:0]  ps_num,
    input wire logic [31:0] ps_wdata,
    input wire logic [31:0] ps_rdata,
    input wire logic        ps_rvalid,
    // Straps and activity
    input wire logic [31:0] otp_security_word,
    input wire logic        threads_all_paused,
    // Observed outputs
    input wire logic        rgmii_port_en,
    input wire logic        rgmii_tx_clk,
    input wire logic        rgmii_tx_data_strobe,
    input wire logic        core_clk_divide,
    input wire logic        global_debug_block,
    input wire logic        otp_master_lock,
    input wire logic [3:0]  otp_sector_lock,
    input wire logic        protected_boot_select,
    input wire logic        pll_jtag_block,
    input wire logic        tap_jtag_block,
    input wire logic        core_oscillator_run,
    input wire logic        peripheral_oscillator_run
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////
    // Shadow registers and transmit clock timing
    logic [31:0] ctrl_q, prot_q;
    logic [1:0]  osc_q;
    logic [9:0]  per_q;
    logic        seen_q, clk_prev_q;
    wire         ctrl_wr  = ps_wr && ps_num == TCSR_TILE_CONTROL;
    wire         rise     = rgmii_tx_clk && !clk_prev_q;
    wire  [9:0]  since    = rise ? 10'h000 : per_q;
    wire         div_want = ctrl_q[4] & (~ctrl_q[5] | threads_all_paused);

    // Track writes; seen only after a rise under the current setting
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_q     <= 32'h0;
            prot_q     <= otp_security_word & TCSR_PROT_MASK;
            osc_q      <= 2'h0;
            per_q      <= 10'h000;
            seen_q     <= 1'b0;
            clk_prev_q <= 1'b0;
        end else begin
            if (ctrl_wr) ctrl_q <= ps_wdata & TCSR_CTRL_MASK;
            if (ps_wr && ps_num == TCSR_PROTECTION && !prot_q[31])
                prot_q <= ps_wdata & TCSR_PROT_MASK;
            if (ps_wr && ps_num == TCSR_OSC_CONTROL) osc_q <= ps_wdata[1:0];
            clk_prev_q <= rgmii_tx_clk;
            per_q      <= since + 10'h001;
            seen_q     <= (seen_q | rise) & !ctrl_wr & rgmii_port_en;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Properties
    property p_rd_answer;
        ps_rd |=> ps_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read gave no answer");
    property p_ctrl_read;
        ps_rd && ps_num == TCSR_TILE_CONTROL |=> ps_rdata == $past(ctrl_q);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");
    property p_prot_read;
        ps_rd && ps_num == TCSR_PROTECTION |=> ps_rdata == $past(prot_q);
    endproperty
    a_prot_read: assert property (p_prot_read) else $error("protection readback wrong");
    property p_port_en;
        rgmii_port_en == ctrl_q[8];
    endproperty
    a_port_en: assert property (p_port_en) else $error("port enable wrong");
    property p_divide;
        core_clk_divide == $past(div_want);
    endproperty
    a_divide: assert property (p_divide) else $error("clock divide wrong");
    property p_tx_period;
        rise && seen_q |-> per_q == {1'b0, ctrl_q[17:9]} + 10'h001;
    endproperty
    a_tx_period: assert property (p_tx_period) else $error("tx clock period wrong");
    property p_tx_strobe;
        rgmii_tx_data_strobe && seen_q |-> since == {2'b00, ctrl_q[25:18]};
    endproperty
    a_tx_strobe: assert property (p_tx_strobe) else $error("tx data delay wrong");
    property p_tx_off;
        !rgmii_port_en |=> !rgmii_tx_clk && !rgmii_tx_data_strobe;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("tx active while disabled");
    property p_prot_out;
        {global_debug_block, otp_master_lock, otp_sector_lock, protected_boot_select,
         pll_jtag_block, tap_jtag_block} == {prot_q[14], prot_q[12],
         prot_q[11:8] | {4{prot_q[12]}}, prot_q[5], prot_q[4], prot_q[0]};
    endproperty
    a_prot_out: assert property (p_prot_out) else $error("protection output wrong");
    property p_osc_run;
        {core_oscillator_run, peripheral_oscillator_run} == osc_q;
    endproperty
    a_osc_run: assert property (p_osc_run) else $error("oscillator run wrong");
endmodule // tcsr_regs_checker

bind tcsr_regs tcsr_regs_checker i_tcsr_regs_checker (.*);

// [tb/tcsr_regs_tb.sv]
module tcsr_regs_tb
    import tcsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // Stimulus with time zero values
    logic        ref_clk = 1'b0, rst_n = 1'b0, ps_wr = 1'b0, ps_rd = 1'b0, boot_from_ram = 1'b0;
    logic        core1_powered = 1'b1, boot_from_jtag = 1'b1, skip_otp_poll = 1'b1;
    logic        threads_all_paused = 1'b0;
    logic [7:0]  ps_num = 8'h00, proc_number = 8'hA5;
    logic [31:0] ps_wdata = 32'h0, otp_security_word = 32'h7FFF_FFFF;
    logic [1:0]  boot_pll_mode = 2'h2;
    logic [3:0]  osc_tick = 4'h0;
    // Design results
    logic [31:0] ps_rdata;
    logic [3:0]  otp_sector_lock;
    logic        ps_rvalid, rgmii_port_en, rgmii_tx_clk, rgmii_tx_data_strobe, core_clk_divide;
    logic        global_debug_block, otp_master_lock, otp_redundancy_en, protected_boot_select;
    logic        pll_jtag_block, tap_jtag_block, core_oscillator_run, peripheral_oscillator_run;
    // Bench state
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h5490;
    logic [31:0] v, w;
    int          n_fail = 0, num_checks = 0;

    tcsr_regs i_tcsr_regs (.*);

    always #25 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] num, input logic [31:0] data);
        @(posedge ref_clk);
        ps_wr    <= 1'b1;
        ps_num   <= num;
        ps_wdata <= data;
        @(posedge ref_clk);
        ps_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] num, input logic [31:0] exp);
        exp_q.push_back(exp);
        @(posedge ref_clk);
        ps_rd  <= 1'b1;
        ps_num <= num;
        @(posedge ref_clk);
        ps_rd <= 1'b0;
    endtask

    // Count tx clock highs, rises and strobes over four periods
    task automatic tx(input int dv, input int dl);
        int hi = 0;
        int rs = 0;
        int st = 0;
        logic pv;
        wr(TCSR_TILE_CONTROL, 32'h0);
        wr(TCSR_TILE_CONTROL, 32'((dl << 18) | (dv << 9) | 32'h100));
        repeat (2 * dv + 4) @(negedge ref_clk);
        pv = rgmii_tx_clk;
        repeat (4 * (dv + 1)) begin
            @(negedge ref_clk);
            hi += int'(rgmii_tx_clk === 1'b1);
            rs += int'(rgmii_tx_clk === 1'b1 && pv === 1'b0);
            st += int'(rgmii_tx_data_strobe === 1'b1);
            pv = rgmii_tx_clk;
        end
        chk(hi, 4 * ((dv >> 1) + 1));
        chk(rs, 4);
        chk(st, 4);
    endtask

    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            osc_tick <= 4'hF;
            @(posedge ref_clk);
            osc_tick <= 4'h0;
            repeat (3) @(posedge ref_clk);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Read answers against the oldest note
    always @(negedge ref_clk) begin
        if (ps_rvalid === 1'b1) begin
            chk(ps_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hXXXX_XXXX);
        end
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        results();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(TCSR_TILE_CONTROL, 32'h0);
        rd(TCSR_OSC_CONTROL, 32'h0);
        rd(TCSR_PROTECTION, 32'h0000_5FB1);
        wr(TCSR_BOOT_STATUS, 32'hFFFF_FFFF);
        rd(8'h04, 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = xs();
            {proc_number, core1_powered, skip_otp_poll} <= {v[31:24], v[5], v[4]};
            {boot_from_ram, boot_from_jtag, boot_pll_mode} <= {v[3], v[2], v[1:0]};
            rd(TCSR_BOOT_STATUS, {8'h00, v[31:24], 7'h00, 1'b1, 2'h0, v[5:0]});
        end
        $display("test boot_status done");
        for (int i = 0; i < 8; i++) begin
            v = xs();
            v[5:4] = {i[0], ~i[2]};
            threads_all_paused <= i[1];
            wr(TCSR_TILE_CONTROL, v);
            // Divide flag is registered, so let one more edge pass
            repeat (2) @(negedge ref_clk);
            chk(rgmii_port_en, v[8]);
            chk(core_clk_divide, v[4] & (~v[5] | i[1]));
            rd(TCSR_TILE_CONTROL, v & TCSR_CTRL_MASK);
        end
        $display("test tile_control done");
        for (int i = 0; i < 2; i++) begin
            v = xs() & 32'h7FFF_EFFF | (i << 12);
            wr(TCSR_PROTECTION, v);
            @(negedge ref_clk);
            chk({global_debug_block, otp_master_lock, otp_sector_lock, otp_redundancy_en,
                 protected_boot_select, pll_jtag_block, tap_jtag_block},
                {v[14], v[12], v[11:8] | {4{v[12]}}, v[7], v[5], v[4], v[0]});
            rd(TCSR_PROTECTION, v & TCSR_PROT_MASK);
        end
        w = v | 32'h8000_0000;
        wr(TCSR_PROTECTION, w);
        wr(TCSR_PROTECTION, ~w);
        rd(TCSR_PROTECTION, w & TCSR_PROT_MASK);
        $display("test protection done");
        tx(2, 0);
        tx(3, 2);
        tx(8, 5);
        wr(TCSR_TILE_CONTROL, 32'h0);
        $display("test tx_clock done");
        wr(TCSR_OSC_CONTROL, 32'h2);
        pulse(5);
        wr(TCSR_OSC_CONTROL, 32'h1);
        pulse(3);
        wr(TCSR_OSC_CONTROL, 32'h0);
        repeat (10) @(posedge ref_clk);
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 4; i++) begin
                rd(TCSR_OSC_COUNT0 + 8'(i), i < 2 ? 32'h5 : 32'h3);
            end
            rst_n <= 1'b0;
            repeat (20) @(posedge ref_clk);
            rst_n <= 1'b1;
        end
        rd(TCSR_PROTECTION, 32'h0000_5FB1);
        $display("test oscillators done");
        repeat (3) @(posedge ref_clk);
        chk(exp_q.size(), 0);
        results();
    end
endmodule // tcsr_regs_tb
